// [tac_core.sv]
`timescale 1ns/1ps
// Behaviour
// - triple DES ECB on 64-bit blocks, 112-bit or 168-bit key
// - only keying option 1 (three keys) and option 2 (third equals first)
// - AES ECB on 128-bit blocks with 128, 192 or 256-bit keys
// - a key write overwrites the whole stored key, nothing old remains
// - reset loads the stored key with random content
module tac_core (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [255:0] ent_in,
    input  wire logic         key_wr,
    input  wire logic [255:0] key_in,
    input  wire logic         alg_sel,
    input  wire logic         decrypt,
    input  wire logic [1:0]   key_len,
    input  wire logic         tdes_3key,
    input  wire logic         start,
    input  wire logic [127:0] blk_in,
    output logic              busy,
    output logic              done,
    output logic [127:0]      blk_out
);
    localparam int DES_LAT    = 49;
    localparam int AES128_LAT = 56;
    localparam int AES256_LAT = 76;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    tac_pkg::tac_state_e state_q, state_d;
    logic [255:0] key_q;
    logic [127:0] data_q, blk_out_q, aes_nxt, aes_rkey;
    logic [55:0]  cd_q, cd_use, cd_nxt, cd_load, cd_first_q;
    logic [63:0]  des_nxt;
    logic [31:0]  rk [0:59];
    logic [31:0]  w_new, w_tmp, w_prev, key_word;
    logic [255:0] key_sh;
    logic [3:0]   rnd_q, rnd_d, nk, nr, rk_idx, wj_q;
    logic [5:0]   wi_q, nw, rk_base;
    logic [1:0]   pass_q, pass_d, klen_q, load_pass;
    logic [7:0]   rcon_q;
    logic [4:0]   r1, sh_r;
    logic         alg_q, dec_q, k3_q, done_q, fin, accept, dec_pass, sh1, first_q;
    logic         pass_end, dec_w, k3_w;

    function automatic logic [7:0] xt(input logic [7:0] a);
        xt = {a[6:0], 1'b0} ^ (a[7] ? tac_pkg::AES_POLY : 8'h00);
    endfunction : xt

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        gmul = p;
    endfunction : gmul

    function automatic logic [7:0] rotb(input logic [7:0] b, input int n);
        logic [15:0] t;
        t = {b, b} << n;
        rotb = t[15:8];
    endfunction : rotb

    // field inverse by x^254 wrapped in the affine map or its inverse
    function automatic logic [7:0] sbox(input logic [7:0] x, input logic inv);
        logic [7:0] y;
        logic [7:0] p;
        logic [7:0] r;
        y = inv ? (rotb(x, 1) ^ rotb(x, 3) ^ rotb(x, 6) ^ tac_pkg::AES_IAFF_C) : x;
        r = 8'h01;
        p = y;
        for (int i = 0; i < 7; i++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        sbox = inv ? r : (r ^ rotb(r, 1) ^ rotb(r, 2) ^ rotb(r, 3) ^ rotb(r, 4) ^ tac_pkg::AES_AFF_C);
    endfunction : sbox

    function automatic logic [127:0] sub_all(input logic [127:0] s, input logic inv);
        for (int n = 0; n < 16; n++) sub_all[8*n +: 8] = sbox(s[8*n +: 8], inv);
    endfunction : sub_all

    // byte n of the state sits at [127-8n], column major
    function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
        int sc;
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 4; c++) begin
                sc = inv ? (c - r + 4) % 4 : (c + r) % 4;
                shift_rows[127-8*(r+4*c) -: 8] = s[127-8*(r+4*sc) -: 8];
            end
        end
    endfunction : shift_rows

    function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
        logic [15:0] cf;
        logic [7:0]  acc;
        cf = inv ? tac_pkg::AES_MIX_INV : tac_pkg::AES_MIX_FWD;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                acc = 8'h00;
                for (int k = 0; k < 4; k++)
                    acc = acc ^ gmul({4'h0, cf[15-4*((k-r+4)%4) -: 4]}, s[127-8*(4*c+k) -: 8]);
                mix[127-8*(4*c+r) -: 8] = acc;
            end
        end
    endfunction : mix

    function automatic logic [31:0] sub_word(input logic [31:0] w);
        for (int n = 0; n < 4; n++) sub_word[8*n +: 8] = sbox(w[8*n +: 8], 1'b0);
    endfunction : sub_word

    // initial permutation, inverse gives the final one; bit 1 is the msb
    function automatic logic [63:0] ip_perm(input logic [63:0] v, input logic inv);
        int src;
        ip_perm = 64'h0;
        for (int i = 0; i < 64; i++) begin
            src = ((i / 8) < 4 ? 58 + 2 * (i / 8) : 49 + 2 * (i / 8)) - 8 * (i % 8);
            if (inv) ip_perm[64-src] = v[63-i];
            else ip_perm[63-i] = v[64-src];
        end
    endfunction : ip_perm

    function automatic logic [55:0] pc1(input logic [63:0] k);
        int sl;
        int sr;
        for (int i = 0; i < 28; i++) begin
            sl = 57 - 8 * (i % 8) + i / 8;
            sr = (i < 24) ? 63 - 8 * (i % 8) - i / 8 : 28 - 8 * (i - 24);
            pc1[55-i] = k[64-sl];
            pc1[27-i] = k[64-sr];
        end
    endfunction : pc1

    function automatic logic [47:0] pc2(input logic [55:0] cd);
        for (int i = 0; i < 48; i++) pc2[47-i] = cd[56-int'(tac_pkg::DES_PC2_TBL[383-8*i -: 8])];
    endfunction : pc2

    function automatic logic [27:0] rot28(input logic [27:0] h, input logic two, input logic left);
        logic [55:0] d;
        d = {h, h};
        if (left) rot28 = two ? d[53:26] : d[54:27];
        else rot28 = two ? d[29:2] : d[28:1];
    endfunction : rot28

    function automatic logic [31:0] des_f(input logic [31:0] r, input logic [47:0] k);
        logic [47:0] x;
        logic [31:0] s;
        logic [5:0]  six;
        int          idx;
        for (int i = 0; i < 48; i++) x[47-i] = r[31-((4*(i/6) + i%6 + 31) % 32)];
        x = x ^ k;
        for (int b = 0; b < 8; b++) begin
            six = x[47-6*b -: 6];
            idx = 64 * b + 16 * {six[5], six[0]} + six[4:1];
            s[31-4*b -: 4] = tac_pkg::DES_SBOX[2047-4*idx -: 4];
        end
        for (int i = 0; i < 32; i++) des_f[31-i] = s[32-int'(tac_pkg::DES_P_TBL[255-8*i -: 8])];
    endfunction : des_f

    // pass keys: encrypt K1,K2,K3 / decrypt K3,K2,K1; two-key mode reuses K1
    function automatic logic [63:0] pass_key(input logic [255:0] k, input logic [1:0] p,
                                             input logic dec, input logic k3);
        logic [63:0] k3v;
        k3v = k3 ? k[127:64] : k[255:192];
        if (p == 2'h1) pass_key = k[191:128];
        else if ((p == 2'h0) == dec) pass_key = k3v;
        else pass_key = k[255:192];
    endfunction : pass_key

    // handshake and mode decode
    assign accept  = start && (state_q == tac_pkg::ST_IDLE);
    assign busy    = (state_q != tac_pkg::ST_IDLE);
    assign done    = done_q;
    assign blk_out = blk_out_q;
    assign nk      = (klen_q == tac_pkg::KLEN_192) ? tac_pkg::AES_NK_192 :
                     (klen_q == tac_pkg::KLEN_256) ? tac_pkg::AES_NK_256 : tac_pkg::AES_NK_128;
    assign nr      = nk + tac_pkg::AES_NR_EXTRA;
    assign nw      = {nr, 2'h0} + 6'h04;

    // key schedule, one word per cycle into the round key array
    assign key_sh   = key_q << {wi_q, 5'h00};
    assign key_word = key_sh[255:224];
    assign w_prev   = rk[wi_q - 6'h01];
    assign w_tmp    = (wj_q == 4'h0) ? (sub_word({w_prev[23:0], w_prev[31:24]}) ^ {rcon_q, 24'h0}) :
                      (nk == tac_pkg::AES_NK_256 && wj_q == 4'h4) ? sub_word(w_prev) : w_prev;
    assign w_new    = (wi_q < {2'h0, nk}) ? key_word : (rk[wi_q - {2'h0, nk}] ^ w_tmp);

    // AES round: initial key add at round 0, no column mix in the last round
    assign rk_idx   = dec_q ? (nr - rnd_q) : rnd_q;
    assign rk_base  = {rk_idx, 2'h0};
    assign aes_rkey = {rk[rk_base], rk[rk_base + 6'h01], rk[rk_base + 6'h02], rk[rk_base + 6'h03]};
    assign aes_nxt  = (rnd_q == 4'h0) ? (data_q ^ aes_rkey) :
                      !dec_q ? (((rnd_q == nr) ? shift_rows(sub_all(data_q, 1'b0), 1'b0) :
                                 mix(shift_rows(sub_all(data_q, 1'b0), 1'b0), 1'b0)) ^ aes_rkey) :
                      ((rnd_q == nr) ? (sub_all(shift_rows(data_q, 1'b1), 1'b1) ^ aes_rkey) :
                       mix(sub_all(shift_rows(data_q, 1'b1), 1'b1) ^ aes_rkey, 1'b1));

    // DES round: middle pass runs the opposite direction
    assign dec_pass  = dec_q ^ (pass_q == 2'h1);
    assign r1        = {1'b0, rnd_q} + 5'h01;
    assign sh_r      = dec_pass ? (5'h11 - r1) : r1;
    assign sh1       = (sh_r == 5'h01) || (sh_r == 5'h02) || (sh_r == 5'h09) || (sh_r == 5'h10);
    assign cd_use    = dec_pass ? cd_q : {rot28(cd_q[55:28], !sh1, 1'b1), rot28(cd_q[27:0], !sh1, 1'b1)};
    assign cd_nxt    = dec_pass ? {rot28(cd_q[55:28], !sh1, 1'b0), rot28(cd_q[27:0], !sh1, 1'b0)} : cd_use;
    assign des_nxt   = (rnd_q == tac_pkg::DES_LAST_RND) ?
                       {data_q[63:32] ^ des_f(data_q[31:0], pc2(cd_use)), data_q[31:0]} :
                       {data_q[31:0], data_q[63:32] ^ des_f(data_q[31:0], pc2(cd_use))};
    assign pass_end  = (state_q == tac_pkg::ST_DES) && (rnd_q == tac_pkg::DES_LAST_RND) &&
                       (pass_q != tac_pkg::DES_LAST_PASS);
    assign load_pass = accept ? 2'h0 : (pass_q + 2'h1);
    assign dec_w     = accept ? decrypt : dec_q;
    assign k3_w      = accept ? tdes_3key : k3_q;
    assign cd_load   = pc1(pass_key(key_q, load_pass, dec_w, k3_w));

    // sequencing
    always_comb begin
        state_d = state_q;
        rnd_d   = rnd_q;
        pass_d  = pass_q;
        fin     = 1'b0;
        case (state_q)
            tac_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = alg_sel ? tac_pkg::ST_KEXP : tac_pkg::ST_DES;
                    rnd_d   = 4'h0;
                    pass_d  = 2'h0;
                end
            end
            tac_pkg::ST_KEXP: begin
                if (wi_q == nw - 6'h01) state_d = tac_pkg::ST_AES;
            end
            tac_pkg::ST_AES: begin
                rnd_d = rnd_q + 4'h1;
                if (rnd_q == nr) begin
                    state_d = tac_pkg::ST_IDLE;
                    fin     = 1'b1;
                end
            end
            tac_pkg::ST_DES: begin
                rnd_d = rnd_q + 4'h1;
                if (rnd_q == tac_pkg::DES_LAST_RND) begin
                    pass_d = pass_q + 2'h1;
                    if (pass_q == tac_pkg::DES_LAST_PASS) begin
                        state_d = tac_pkg::ST_IDLE;
                        fin     = 1'b1;
                    end
                end
            end
            default: state_d = tac_pkg::ST_IDLE;
        endcase
    end

    // control registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= tac_pkg::ST_IDLE;
            rnd_q   <= 4'h0;
            pass_q  <= 2'h0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            rnd_q   <= rnd_d;
            pass_q  <= pass_d;
            done_q  <= fin;
        end
    end

    // mode captured at an accepted start only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {alg_q, dec_q, k3_q, klen_q} <= 5'h00;
        end else if (accept) begin
            {alg_q, dec_q, k3_q, klen_q} <= {alg_sel, decrypt, tdes_3key, key_len};
        end
    end

    // stored key: random at reset, whole-width overwrite on every write
    always_ff @(posedge mclk) begin
        if (sys_rst) key_q <= ent_in;
        else if (key_wr) key_q <= key_in;
    end

    // key schedule counters
    always_ff @(posedge mclk) begin
        if (sys_rst || accept) begin
            wi_q   <= 6'h00;
            wj_q   <= 4'h0;
            rcon_q <= tac_pkg::AES_RCON_INIT;
        end else if (state_q == tac_pkg::ST_KEXP) begin
            wi_q <= wi_q + 6'h01;
            wj_q <= (wj_q == nk - 4'h1) ? 4'h0 : wj_q + 4'h1;
            if (wi_q >= {2'h0, nk} && wj_q == 4'h0) rcon_q <= xt(rcon_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (state_q == tac_pkg::ST_KEXP) rk[wi_q] <= w_new;
    end

    // datapath and result
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_q    <= 128'h0;
            cd_q      <= 56'h0;
            blk_out_q <= 128'h0;
        end else begin
            if (accept) data_q <= alg_sel ? blk_in : {64'h0, ip_perm(blk_in[63:0], 1'b0)};
            else if (state_q == tac_pkg::ST_AES) data_q <= aes_nxt;
            else if (state_q == tac_pkg::ST_DES) data_q <= {64'h0, des_nxt};
            if (accept || pass_end) cd_q <= cd_load;
            else if (state_q == tac_pkg::ST_DES) cd_q <= cd_nxt;
            if (fin) blk_out_q <= alg_q ? aes_nxt : {64'h0, ip_perm(des_nxt, 1'b1)};
        end
    end

    // helper: first pass key state, for the two-key check
    always_ff @(posedge mclk) begin
        first_q <= accept && !sys_rst;
        if (first_q) cd_first_q <= cd_q;
    end

    sequence s_des_go;
        accept && (alg_sel == tac_pkg::ALG_TDES);
    endsequence
    sequence s_aes128_go;
        accept && (alg_sel == tac_pkg::ALG_AES) && (key_len == tac_pkg::KLEN_128);
    endsequence
    sequence s_aes256_go;
        accept && (alg_sel == tac_pkg::ALG_AES) && (key_len == tac_pkg::KLEN_256);
    endsequence

    a_des_latency: assert property (s_des_go |-> ##DES_LAT done)
        else $error("triple DES result not ready on time");
    a_key_option: assert property (pass_end && pass_q == 2'h1 && !k3_q |=> cd_q == cd_first_q)
        else $error("two-key mode third pass key differs from first");
    a_aes128_time: assert property (s_aes128_go |=> busy [*8] ##(AES128_LAT-8) done)
        else $error("AES-128 result not ready on time");
    a_aes256_time: assert property (s_aes256_go |=> !done ##(AES256_LAT-1) done)
        else $error("AES-256 result not ready on time");
    a_key_write: assert property (key_wr |=> key_q == $past(key_in))
        else $error("key write did not replace stored key");
    a_reset_rand: assert property (@(posedge mclk) disable iff (1'b0) sys_rst |=> key_q == $past(ent_in))
        else $error("reset did not load random key");
    a_busy_ignore: assert property (busy && start |=> $stable(alg_q) && $stable(dec_q) && (busy || done))
        else $error("start accepted while busy");
    a_done_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done not a single idle pulse");
endmodule : tac_core

// [tac_pkg.sv]
package tac_pkg;
    // algorithm select and AES key length codes
    localparam logic       ALG_TDES      = 1'b0;
    localparam logic       ALG_AES       = 1'b1;
    localparam logic [1:0] KLEN_128      = 2'h0;
    localparam logic [1:0] KLEN_192      = 2'h1;
    localparam logic [1:0] KLEN_256      = 2'h2;

    // AES key schedule shape: words per key, rounds = words + 6
    localparam logic [3:0] AES_NK_128    = 4'h4;
    localparam logic [3:0] AES_NK_192    = 4'h6;
    localparam logic [3:0] AES_NK_256    = 4'h8;
    localparam logic [3:0] AES_NR_EXTRA  = 4'h6;
    localparam logic [7:0] AES_RCON_INIT = 8'h01;
    localparam logic [7:0] AES_POLY      = 8'h1B;
    localparam logic [7:0] AES_AFF_C     = 8'h63;
    localparam logic [7:0] AES_IAFF_C    = 8'h05;
    // column mixing coefficients, one nibble per distance
    localparam logic [15:0] AES_MIX_FWD  = 16'h2311;
    localparam logic [15:0] AES_MIX_INV  = 16'hEBD9;

    // triple DES sequencing: 16 rounds per pass, three passes
    localparam logic [3:0] DES_LAST_RND  = 4'hF;
    localparam logic [1:0] DES_LAST_PASS = 2'h2;

    // eight substitution boxes, 64 nibbles each, entry 0 first
    localparam logic [2047:0] DES_SBOX = {
        256'hE4D12FB83A6C59070F74E2D1A6CB953841E8D62BFC973A50FC8249175B3EA06D,
        256'hF18E6B34972DC05A3D47F28EC01A69B50E7BA4D158C6932FD8A13F42B67C05E9,
        256'hA09E63F51DC7B428D709346A285ECBF1D6498F30B12C5AE71AD069874FE3B52C,
        256'h7DE3069A1285BC4FD8B56F03472C1AE9A690CB7DF13E52843F06A1D8945BC72E,
        256'h2C417AB6853FD0E9EB2C47D150FA3986421BAD78F9C5630EB8C71E2D6F09A453,
        256'hC1AF92680D34E75BAF427C9561DE0B389EF528C3704A1DB6432C95FABE17608D,
        256'h4B2EF08D3C975A61D0B7491AE35C2F8614BDC37EAF6805926BD814A7950FE23C,
        256'hD2846FB1A93E50C71FD8A374C56B0E927B419CE206ADF35821E74A8DFC90356B};
    // round output permutation and subkey selection, one source bit per byte
    localparam logic [255:0] DES_P_TBL =
        256'h1007141D1D0C1C11010F171A05121F0A0208180E201B0309130D1E06160B0419 ^
        256'h0000000800000000000000000000000000000000000000000000000000000000;
    localparam logic [383:0] DES_PC2_TBL =
        384'h0E110B180105031C0F06150A17130C041A0810071B140D0229341F252F371E28332D21302C31273822352E2A32241D20;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_KEXP = 2'b01,
        ST_AES  = 2'b10,
        ST_DES  = 2'b11
    } tac_state_e;
endpackage : tac_pkg

// [tac_host.sv]
`timescale 1ns/1ps
// processor-side model: writes keys, issues one block per start, times done
module tac_host (
    input  wire logic         mclk,
    input  wire logic         busy,
    input  wire logic         done,
    input  wire logic [127:0] blk_out,
    output logic              key_wr,
    output logic [255:0]      key_in,
    output logic              alg_sel,
    output logic              decrypt,
    output logic [1:0]        key_len,
    output logic              tdes_3key,
    output logic              start,
    output logic [127:0]      blk_in
);
    // quiet request lines at time zero
    initial begin
        key_wr    = 1'b0;
        key_in    = '0;
        {alg_sel, decrypt, tdes_3key, start} = 4'h0;
        key_len   = 2'h0;
        blk_in    = '0;
    end

    // whole key in one strobe cycle, bus inverted once released
    task automatic write_key(input logic [255:0] k);
        @(negedge mclk);
        key_wr = 1'b1;
        key_in = k;
        @(negedge mclk);
        key_wr = 1'b0;
        key_in = ~k;
    endtask : write_key

    // mode and block valid on the accept edge only; poke raises start again while busy
    task automatic run_op(input logic alg, input logic dec, input logic [1:0] kl, input logic k3,
                          input logic [127:0] blk, input int poke, output logic [127:0] res, output int lat);
        @(negedge mclk);
        alg_sel   = alg;
        decrypt   = dec;
        key_len   = kl;
        tdes_3key = k3;
        blk_in    = blk;
        start     = (busy !== 1'b1);
        lat       = 0;
        while (lat < 200) begin
            @(negedge mclk);
            start = (lat == poke);
            {alg_sel, decrypt, tdes_3key} = ~{alg, dec, k3};
            key_len = ~kl;
            blk_in  = ~blk;
            @(posedge mclk);
            #1;
            lat++;
            if (done === 1'b1) break;
        end
        // done is seen here just after its launch edge; it is sampled at the next one
        lat++;
        res = blk_out;
    endtask : run_op
endmodule : tac_host

// [tdes_aes_ecb_cipher_tb.sv]
`timescale 1ns/1ps
module tdes_aes_ecb_cipher_tb;
    typedef struct packed {
        logic         alg;
        logic         dec;
        logic [1:0]   kl;
        logic         k3;
        logic [255:0] key;
        logic [127:0] din;
        logic [127:0] dout;
        logic [7:0]   lat;
    } tac_row_s;

    localparam logic         AES   = tac_pkg::ALG_AES;
    localparam logic         DES   = tac_pkg::ALG_TDES;
    localparam logic [1:0]   K128  = tac_pkg::KLEN_128;
    localparam logic [1:0]   K192  = tac_pkg::KLEN_192;
    localparam logic [1:0]   K256  = tac_pkg::KLEN_256;
    localparam logic [255:0] K_AES = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
    localparam logic [127:0] P_AES = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] C128  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] C192  = 128'hDDA97CA4864CDFE06EAF70A0EC0D7191;
    localparam logic [127:0] C256  = 128'h8EA2B7CA516745BFEAFC49904B496089;
    localparam logic [255:0] KT3   = 256'h0123456789ABCDEF23456789ABCDEF01456789ABCDEF01230000000000000000;
    localparam logic [255:0] KTE   = {{3{64'h133457799BBCDFF1}}, 64'h0};
    localparam logic [255:0] KT2   = 256'h0123456789ABCDEF0123456789ABCDEF5A5AC3C3F00F96690000000000000000;
    localparam logic [63:0]  PT3   = 64'h5468652071756663;
    localparam logic [63:0]  CT3   = 64'hA826FD8CE53B855F;
    localparam logic [63:0]  PT2   = 64'h4E6F772069732074;
    localparam logic [63:0]  CT2   = 64'h3FA40E8A984D4815;

    logic         mclk;
    logic         sys_rst;
    logic [255:0] ent_in;
    logic         key_wr;
    logic [255:0] key_in;
    logic         alg_sel;
    logic         decrypt;
    logic [1:0]   key_len;
    logic         tdes_3key;
    logic         start;
    logic [127:0] blk_in;
    logic         busy;
    logic         done;
    logic [127:0] blk_out;
    logic [127:0] res;
    int           lat;
    int           k;
    int           cyc;
    int           n_mismatch;
    int           n_compared;
    tac_row_s     rows [12];

    tac_core dut (.mclk(mclk), .sys_rst(sys_rst), .ent_in(ent_in), .key_wr(key_wr), .key_in(key_in),
                  .alg_sel(alg_sel), .decrypt(decrypt), .key_len(key_len), .tdes_3key(tdes_3key),
                  .start(start), .blk_in(blk_in), .busy(busy), .done(done), .blk_out(blk_out));

    tac_host host (.mclk(mclk), .busy(busy), .done(done), .blk_out(blk_out), .key_wr(key_wr),
                   .key_in(key_in), .alg_sel(alg_sel), .decrypt(decrypt), .key_len(key_len),
                   .tdes_3key(tdes_3key), .start(start), .blk_in(blk_in));

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // counts and the single ending point
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    // cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        ent_in = K_AES;
        cyc = 0;
        n_mismatch = 0;
        n_compared = 0;
        rows = '{
            '{AES, 1'b0, K128, 1'b0, K_AES, P_AES, C128, 8'h38},
            '{AES, 1'b1, K128, 1'b0, K_AES, C128, P_AES, 8'h38},
            '{AES, 1'b0, K192, 1'b0, K_AES, P_AES, C192, 8'h42},
            '{AES, 1'b1, K192, 1'b0, K_AES, C192, P_AES, 8'h42},
            '{AES, 1'b0, K256, 1'b0, K_AES, P_AES, C256, 8'h4C},
            '{AES, 1'b1, K256, 1'b0, K_AES, C256, P_AES, 8'h4C},
            '{AES, 1'b0, 2'h3, 1'b0, K_AES, P_AES, C128, 8'h38},
            '{DES, 1'b0, K128, 1'b1, KT3, {2{PT3}}, {64'h0, CT3}, 8'h31},
            '{DES, 1'b1, K128, 1'b1, KT3, {2{CT3}}, {64'h0, PT3}, 8'h31},
            '{DES, 1'b0, K128, 1'b1, KTE, {2{64'h0123456789ABCDEF}}, {64'h0, 64'h85E813540F0AB405}, 8'h31},
            '{DES, 1'b0, K128, 1'b0, KT2, {2{PT2}}, {64'h0, CT2}, 8'h31},
            '{DES, 1'b1, K128, 1'b0, KT2, {2{CT2}}, {64'h0, PT2}, 8'h31}};
        repeat (5) @(posedge mclk);
        #1;
        chk(busy === 1'b0 && done === 1'b0 && blk_out === '0, "outputs in reset");
        @(negedge mclk);
        sys_rst = 1'b0;
        // key store comes from the reset load, no key write
        host.run_op(AES, 1'b0, K128, 1'b0, P_AES, -1, res, lat);
        chk(res === C128, "key loaded at reset");
        // table of known answers, a fresh key written before each
        foreach (rows[i]) begin
            host.write_key(rows[i].key);
            host.run_op(rows[i].alg, rows[i].dec, rows[i].kl, rows[i].k3, rows[i].din, -1, res, lat);
            chk(res === rows[i].dout, $sformatf("row %0d result", i));
            chk(lat == int'(rows[i].lat), $sformatf("row %0d latency", i));
        end
        // back to back: second start in the done cycle
        host.write_key(K_AES);
        host.run_op(AES, 1'b0, K128, 1'b0, P_AES, -1, res, lat);
        host.run_op(AES, 1'b1, K128, 1'b0, res, -1, res, lat);
        chk(res === P_AES && lat == 56, "back to back");
        // start while busy is dropped, one done only
        host.run_op(AES, 1'b0, K256, 1'b0, P_AES, 10, res, lat);
        chk(res === C256 && lat == 76, "start while busy");
        k = 0;
        repeat (90) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1 || busy === 1'b1) k++;
        end
        chk(k == 0, "extra operation after busy start");
        // second reset replaces the stored key with the reset load
        @(negedge mclk);
        ent_in = KT3;
        sys_rst = 1'b1;
        repeat (5) @(negedge mclk);
        chk(busy === 1'b0 && done === 1'b0 && blk_out === '0, "outputs in second reset");
        sys_rst = 1'b0;
        host.run_op(DES, 1'b0, K128, 1'b1, {2{PT3}}, -1, res, lat);
        chk(res === {64'h0, CT3} && lat == 49, "key after second reset");
        print_verdict();
    end
endmodule : tdes_aes_ecb_cipher_tb
